//--- iopf_pkg.sv
// constants and register map of the incremental port and input filter
// assumes a 50 MHz core clock and a single AHB-Lite master
package iopf_pkg;
    // ==========================================================
    // timing
    localparam int CLK_NS = 20;
    localparam int POS_CYCLE_NS = 200000;
    localparam int POS_CYCLE_CNT = POS_CYCLE_NS / CLK_NS;
    localparam int INTERP_NS = 400000;
    localparam int INTERP_CNT = INTERP_NS / CLK_NS;
    localparam logic [2:0] FILT_LAST = 3'h3;
    localparam logic [1:0] EMU_GAP_M1 = 2'h1;
    // ==========================================================
    // sizes
    localparam int NUM_DIN = 9;
    localparam int NUM_DOUT = 3;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RX_LINES = 8'h04;
    localparam logic [7:0] ADDR_TX_LINES = 8'h08;
    localparam logic [7:0] ADDR_TX_DELTA = 8'h0C;
    localparam logic [7:0] ADDR_RX_POS = 8'h10;
    localparam logic [7:0] ADDR_RX_IDX = 8'h14;
    localparam logic [7:0] ADDR_DIN = 8'h18;
    localparam logic [7:0] ADDR_DOUT = 8'h1C;
    localparam logic [7:0] ADDR_DIN_MAP = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    localparam logic [7:0] ADDR_CAP_START = 8'h28;
    localparam logic [7:0] ADDR_CAP_SAMP = 8'h2C;
    // ==========================================================
    // control bits
    localparam int CTRL_TX = 0;
    localparam int CTRL_STEP = 1;
    localparam int CTRL_NOIDX = 2;
    localparam int CTRL_CAPEN = 3;
    // status bits
    localparam int ST_CAP_START = 0;
    localparam int ST_CAP_SAMP = 1;
    localparam int ST_INDEX = 2;
    // ==========================================================
    // reset values
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [27:0] RX_M1_RST = 28'h00003FF;
    localparam logic [15:0] TX_M1_RST = 16'h03FF;
    localparam logic [19:0] MAP_RST = 20'h87654;
    // ==========================================================
    // start sequencer states
    typedef enum logic {
        SS_IDLE = 1'b0,
        SS_ARMED = 1'b1
    } iopf_start_t;
endpackage

//--- iopf_top.sv
// incremental port, debounced inputs and delayed outputs, AHB-Lite slave
// assumes synchronous AHB master on core_clk; pins are asynchronous
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module iopf_top #(
    parameter int POS_CYCLES = iopf_pkg::POS_CYCLE_CNT,
    parameter int INTERP_CYCLES = iopf_pkg::INTERP_CNT
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic track_a,
    output logic track_a_drv,
    output logic track_a_oe_n,
    input wire logic track_b,
    output logic track_b_drv,
    output logic track_b_oe_n,
    input wire logic track_n,
    output logic track_n_drv,
    output logic track_n_oe_n,
    input wire logic [iopf_pkg::NUM_DIN-1:0] din,
    output logic [iopf_pkg::NUM_DOUT-1:0] dout,
    output logic controller_enable,
    output logic [1:0] limit_hit,
    output logic [3:0] record_select,
    output logic record_start
);
    import iopf_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [3:0] ctrl;
        logic [27:0] rx_m1;
        logic [15:0] tx_m1;
        logic [19:0] map;
        logic [2:0] dout_reg;
        logic [2:0] dout_pin;
        logic ph_wr;
        logic [7:0] ph_addr;
        logic [31:0] hrdata;
        logic a1, a2, ap, b1, b2, bp, n1, n2, np;
        logic [8:0] din1, din2, dinp;
        logic [31:0] pos_cnt, ip_cnt;
        logic ptick, itick;
        logic [26:0] fcnt;
        logic [8:0] filt;
        logic start_prev;
        iopf_start_t sstate;
        logic [3:0] rec_sel;
        logic rec_strobe;
        logic en_o;
        logic [1:0] lim_o;
        logic [29:0] rx_cnt, rx_idx;
        logic [17:0] emu_cnt;
        logic signed [31:0] emu_pend;
        logic [1:0] emu_gap;
        logic a_o, b_o, n_o;
        logic [31:0] timer, cap_start, cap_samp;
        logic [2:0] status;
    } iopf_state_t;

    iopf_state_t st;
    iopf_state_t next_st;

    function automatic logic pick(input logic [8:0] v, input logic [3:0] s);
        pick = (s < 4'h9) ? v[s] : 1'b0;
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        logic [31:0] rdv;
        logic [2:0] sset, sclr;
        logic signed [31:0] delta, stepv;
        logic [29:0] rx_top;
        logic [17:0] tx_top;
        logic up, dn;
        logic [2:0] fc;
        rdv = 32'h0;
        sset = 3'h0;
        sclr = 3'h0;
        delta = 32'sh0;
        stepv = 32'sh0;
        rx_top = {st.rx_m1, 2'b11};
        tx_top = {st.tx_m1, 2'b11};
        up = 1'b0;
        dn = 1'b0;
        fc = 3'h0;
        next_st = st;
        next_st.rec_strobe = 1'b0;
        // synchronisers
        {next_st.ap, next_st.a2, next_st.a1} = {st.a2, st.a1, track_a};
        {next_st.bp, next_st.b2, next_st.b1} = {st.b2, st.b1, track_b};
        {next_st.np, next_st.n2, next_st.n1} = {st.n2, st.n1, track_n};
        {next_st.dinp, next_st.din2, next_st.din1} = {st.din2, st.din1, din};
        // controller cycle ticks
        next_st.ptick = (st.pos_cnt == POS_CYCLES - 1);
        next_st.pos_cnt = next_st.ptick ? 32'h0 : st.pos_cnt + 32'h1;
        next_st.itick = (st.ip_cnt == INTERP_CYCLES - 1);
        next_st.ip_cnt = next_st.itick ? 32'h0 : st.ip_cnt + 32'h1;
        next_st.timer = st.timer + 32'h1;
        // input debounce, sampled once per position cycle
        for (int i = 0; i < NUM_DIN; i++) begin
            fc = st.fcnt[3*i +: 3];
            if (st.ptick) begin
                if (st.din2[i] == st.filt[i]) begin
                    fc = 3'h0;
                end else if (fc == FILT_LAST) begin
                    next_st.filt[i] = st.din2[i];
                    fc = 3'h0;
                end else begin
                    fc = fc + 3'h1;
                end
            end
            next_st.fcnt[3*i +: 3] = fc;
        end
        // input functions from the map register
        next_st.en_o = pick(st.filt, st.map[7:4]);
        next_st.lim_o = {pick(st.filt, st.map[15:12]),
                         pick(st.filt, st.map[11:8])};
        // positioning start
        unique case (st.sstate)
            SS_IDLE: begin
                if (st.ptick && pick(st.filt, st.map[3:0]) &&
                    !st.start_prev) begin
                    next_st.sstate = SS_ARMED;
                    next_st.rec_sel = st.filt[3:0];
                end
            end
            SS_ARMED: begin
                if (st.itick) begin
                    next_st.rec_strobe = 1'b1;
                    next_st.sstate = SS_IDLE;
                end
            end
        endcase
        if (st.ptick) begin
            next_st.start_prev = pick(st.filt, st.map[3:0]);
            next_st.dout_pin = st.dout_reg;
        end
        // edge timestamps on unfiltered inputs
        if (st.ctrl[CTRL_CAPEN]) begin
            if (pick(st.din2, st.map[3:0]) &&
                !pick(st.dinp, st.map[3:0])) begin
                next_st.cap_start = st.timer;
                sset[ST_CAP_START] = 1'b1;
            end
            if (pick(st.din2, st.map[19:16]) &&
                !pick(st.dinp, st.map[19:16])) begin
                next_st.cap_samp = st.timer;
                sset[ST_CAP_SAMP] = 1'b1;
            end
        end
        // receive decoder
        if (!st.ctrl[CTRL_TX]) begin
            if (st.ctrl[CTRL_STEP]) begin
                up = st.a2 && !st.ap && st.b2;
                dn = st.a2 && !st.ap && !st.b2;
            end else if ((st.a2 ^ st.ap) ^ (st.b2 ^ st.bp)) begin
                up = st.a2 ^ st.bp;
                dn = !(st.a2 ^ st.bp);
            end
            if (up) begin
                next_st.rx_cnt = (st.rx_cnt == rx_top) ? 30'h0 :
                                 st.rx_cnt + 30'h1;
            end else if (dn) begin
                next_st.rx_cnt = (st.rx_cnt == 30'h0) ? rx_top :
                                 st.rx_cnt - 30'h1;
            end
            if (!st.ctrl[CTRL_NOIDX] && st.n2 && !st.np) begin
                next_st.rx_idx = st.rx_cnt;
                sset[ST_INDEX] = 1'b1;
            end
        end
        // encoder emulation, one edge per gap while angle is pending
        if (st.ctrl[CTRL_TX]) begin
            if (st.emu_gap != 2'h0) begin
                next_st.emu_gap = st.emu_gap - 2'h1;
            end else if (st.emu_pend != 32'sh0) begin
                next_st.emu_gap = EMU_GAP_M1;
                if (st.emu_pend > 32'sh0) begin
                    stepv = 32'sh1;
                    next_st.emu_cnt = (st.emu_cnt == tx_top) ? 18'h0 :
                                      st.emu_cnt + 18'h1;
                end else begin
                    stepv = -32'sh1;
                    next_st.emu_cnt = (st.emu_cnt == 18'h0) ? tx_top :
                                      st.emu_cnt - 18'h1;
                end
            end
        end
        // bus data phase
        if (st.ph_wr) begin
            unique case (st.ph_addr)
                ADDR_CTRL: next_st.ctrl = hwdata[3:0];
                ADDR_RX_LINES: next_st.rx_m1 = hwdata[27:0];
                ADDR_TX_LINES: next_st.tx_m1 = hwdata[15:0];
                ADDR_TX_DELTA: delta = signed'(hwdata);
                ADDR_DOUT: next_st.dout_reg = hwdata[2:0];
                ADDR_DIN_MAP: next_st.map = hwdata[19:0];
                ADDR_STATUS: sclr = hwdata[2:0];
                default: ;
            endcase
        end
        next_st.emu_pend = next_st.ctrl[CTRL_TX] ?
                           st.emu_pend + delta - stepv : 32'sh0;
        if (next_st.emu_cnt > {next_st.tx_m1, 2'b11}) begin
            next_st.emu_cnt = 18'h0;
        end
        next_st.a_o = next_st.emu_cnt[1] ^ next_st.emu_cnt[0];
        next_st.b_o = next_st.emu_cnt[1];
        next_st.n_o = next_st.ctrl[CTRL_TX] &&
                      !next_st.ctrl[CTRL_NOIDX] &&
                      (next_st.emu_cnt < 18'h2);
        next_st.status = (st.status & ~sclr) | sset;
        // bus address phase, read data sampled here
        unique case (haddr[7:0])
            ADDR_CTRL: rdv = {28'h0, st.ctrl};
            ADDR_RX_LINES: rdv = {4'h0, st.rx_m1};
            ADDR_TX_LINES: rdv = {16'h0, st.tx_m1};
            ADDR_TX_DELTA: rdv = st.emu_pend;
            ADDR_RX_POS: rdv = {2'h0, st.rx_cnt};
            ADDR_RX_IDX: rdv = {2'h0, st.rx_idx};
            ADDR_DIN: rdv = {23'h0, st.filt};
            ADDR_DOUT: rdv = {29'h0, st.dout_reg};
            ADDR_DIN_MAP: rdv = {12'h0, st.map};
            ADDR_STATUS: rdv = {29'h0, st.status};
            ADDR_CAP_START: rdv = st.cap_start;
            ADDR_CAP_SAMP: rdv = st.cap_samp;
            default: rdv = 32'h0;
        endcase
        next_st.ph_wr = 1'b0;
        if (hsel && htrans[1] && hready) begin
            next_st.ph_wr = hwrite;
            next_st.ph_addr = haddr[7:0];
            if (!hwrite) begin
                next_st.hrdata = rdv;
            end
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.ctrl <= CTRL_RST;
            st.rx_m1 <= RX_M1_RST;
            st.tx_m1 <= TX_M1_RST;
            st.map <= MAP_RST;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.hrdata;
    assign track_a_drv = st.a_o;
    assign track_b_drv = st.b_o;
    assign track_n_drv = st.n_o;
    assign track_a_oe_n = !st.ctrl[CTRL_TX];
    assign track_b_oe_n = !st.ctrl[CTRL_TX];
    assign track_n_oe_n = !st.ctrl[CTRL_TX];
    assign dout = st.dout_pin;
    assign controller_enable = st.en_o;
    assign limit_hit = st.lim_o;
    assign record_select = st.rec_sel;
    assign record_start = st.rec_strobe;

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_armed_tick;
        st.sstate == SS_ARMED && st.itick;
    endsequence

    sequence s_start_seen;
        st.sstate == SS_IDLE ##1 st.sstate == SS_ARMED;
    endsequence

    a_port_dir_excl: assert property (
        !st.ctrl[CTRL_TX] |-> track_a_oe_n && track_b_oe_n &&
        !track_n_drv
    ) else $error("port drives while receiving");
    a_quad_count_up: assert property (
        !st.ctrl[CTRL_TX] && !st.ctrl[CTRL_STEP] && !st.ap && st.a2 &&
        !st.bp && !st.b2 && st.rx_cnt != {st.rx_m1, 2'b11} && !st.ph_wr
        |=> st.rx_cnt == $past(st.rx_cnt) + 30'h1
    ) else $error("quadrature step not counted up");
    a_step_dir_down: assert property (
        !st.ctrl[CTRL_TX] && st.ctrl[CTRL_STEP] && !st.ap && st.a2 &&
        !st.b2 && st.rx_cnt != 30'h0 && !st.ph_wr
        |=> st.rx_cnt == $past(st.rx_cnt) - 30'h1
    ) else $error("step with low direction not counted down");
    a_index_off: assert property (
        st.ctrl[CTRL_NOIDX] |-> !track_n_drv
    ) else $error("index active while disabled");
    a_emu_wrap: assert property (
        st.emu_cnt <= {st.tx_m1, 2'b11}
    ) else $error("emulated count beyond line count");
    a_emu_index: assert property (
        track_n_drv |-> st.emu_cnt < 18'h2 && !st.b_o
    ) else $error("index outside its half period");
    a_emu_burst: assert property (
        $changed(st.emu_cnt) && $past(st.ctrl[CTRL_TX]) &&
        !$past(st.ph_wr) |-> $past(st.emu_pend) != 32'sh0 &&
        $past(st.emu_gap) == 2'h0
    ) else $error("emulated edge without pending angle");
    a_filt_stable: assert property (
        $changed(st.filt[0]) |-> $past(st.ptick) &&
        $past(st.fcnt[2:0]) == FILT_LAST &&
        st.filt[0] == $past(st.din2[0])
    ) else $error("filter passed level too early");
    a_start_on_ip: assert property (
        s_armed_tick |=> st.rec_strobe && st.sstate == SS_IDLE
    ) else $error("start not issued on interpolation tick");
    a_start_cause: assert property (
        s_start_seen |-> $past(st.ptick)
    ) else $error("start armed off the position cycle");
    a_dout_tick: assert property (
        $changed(dout) |-> $past(st.ptick) && dout == $past(st.dout_reg)
    ) else $error("output changed off the position cycle");
    a_cap_time: assert property (
        st.ctrl[CTRL_CAPEN] && st.map[19:16] == 4'h8 && st.din2[8] &&
        !st.dinp[8] |=> st.cap_samp == $past(st.timer) &&
        st.status[ST_CAP_SAMP]
    ) else $error("sample edge time not captured");
endmodule
`default_nettype wire

//--- iopf_enc_model.sv
// encoder / stepper board model on the far side of the incremental port
// assumes the bench resolves each track wire from the port's enables
`timescale 1ns/10ps
`default_nettype none
module iopf_enc_model (
    input wire logic core_clk,
    input wire logic port_rx,
    output logic a_out,
    output logic b_out,
    output logic n_out
);
    // ==========================================================
    // line state
    logic [1:0] ph = 2'h0;
    logic ra = 1'b0;
    logic rb = 1'b0;
    logic rn = 1'b0;
    logic flip = 1'b0;
    always @(posedge core_clk) begin
        flip <= ~flip;
    end
    // released lines show a changing pattern, never the last value
    assign a_out = port_rx ? ra : flip;
    assign b_out = port_rx ? rb : ~flip;
    assign n_out = port_rx ? rn : flip;
    // ==========================================================
    // quadrature steps, A leads when up, edges spaced
    task automatic quad(input logic up, input int n);
        logic [1:0] nx;
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            nx = up ? ph + 2'h1 : ph - 2'h1;
            ph <= nx;
            ra <= nx[1] ^ nx[0];
            rb <= nx[1];
            repeat (3) @(posedge core_clk);
        end
    endtask
    // step pulses on A with direction on B
    task automatic step_dir(input logic up, input int n);
        @(posedge core_clk);
        rb <= up;
        ra <= 1'b0;
        for (int i = 0; i < n; i++) begin
            repeat (3) @(posedge core_clk);
            ra <= 1'b1;
            repeat (3) @(posedge core_clk);
            ra <= 1'b0;
        end
        repeat (3) @(posedge core_clk);
    endtask
    // index pulse
    task automatic index_pulse();
        @(posedge core_clk);
        rn <= 1'b1;
        repeat (4) @(posedge core_clk);
        rn <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

//--- iopf_tb.sv
// self-checking bench of the incremental port and input filter
// assumes iopf_pkg, iopf_top and iopf_enc_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
    import iopf_pkg::*;
    localparam int PC = 8;
    localparam int IC = 20;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [NUM_DIN-1:0] din = '0;
    wire logic hreadyout, hresp;
    wire logic [31:0] hrdata;
    wire logic a_drv, a_oe_n, b_drv, b_oe_n, n_drv, n_oe_n;
    wire logic enc_a, enc_b, enc_n;
    wire logic [NUM_DOUT-1:0] dout;
    wire logic controller_enable, record_start;
    wire logic [1:0] limit_hit;
    wire logic [3:0] record_select;
    int err_total = 0;
    int checked = 0;
    int a_edges, b_edges, n_rises;
    logic pa, pb, pn;
    logic [31:0] rd, p0;
    // ==========================================================
    // wire resolution, only one side drives a track
    wire logic track_a = a_oe_n ? enc_a : a_drv;
    wire logic track_b = b_oe_n ? enc_b : b_drv;
    wire logic track_n = n_oe_n ? enc_n : n_drv;
    iopf_top #(.POS_CYCLES(PC), .INTERP_CYCLES(IC)) u_iopf_top (
        .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .track_a(track_a),
        .track_a_drv(a_drv), .track_a_oe_n(a_oe_n), .track_b(track_b),
        .track_b_drv(b_drv), .track_b_oe_n(b_oe_n), .track_n(track_n),
        .track_n_drv(n_drv), .track_n_oe_n(n_oe_n), .din(din),
        .dout(dout), .controller_enable(controller_enable),
        .limit_hit(limit_hit), .record_select(record_select),
        .record_start(record_start));
    iopf_enc_model u_iopf_enc_model (.core_clk(core_clk),
        .port_rx(a_oe_n), .a_out(enc_a), .b_out(enc_b), .n_out(enc_n));
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    // transmit edge counters
    always @(posedge core_clk) begin
        if (a_drv !== pa) a_edges++;
        if (b_drv !== pb) b_edges++;
        if (n_drv === 1'b1 && pn !== 1'b1) n_rises++;
        pa = a_drv;
        pb = b_drv;
        pn = n_drv;
    end
    // ==========================================================
    // common tasks
    task automatic test_done();
        if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task automatic wait_rdy();
        int k;
        k = 0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1 && k < 50) begin
            @(posedge core_clk);
            k++;
        end
        if (k == 50) begin
            err_total++;
            test_done();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= 1'b1;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= 1'b0;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        wait_rdy();
        d = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
        logic [31:0] d;
        rdr(a, d);
        chk(nm, e, d);
    endtask
    // cycles until a design output equals a value, bounded
    task automatic cycles_to(input int sel, input logic [31:0] e,
                             input int lim, output int n);
        logic [31:0] v;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
            case (sel)
                0: v = {31'h0, controller_enable};
                1: v = {29'h0, dout};
                default: v = {31'h0, record_start};
            endcase
        end while (v !== e && n < lim);
        @(posedge core_clk);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk("dout width", 32'd3, $bits(dout));
        chk("din width", 32'd9, $bits(din));
        chk("oe_n", 32'h7, {29'h0, a_oe_n, b_oe_n, n_oe_n});
        rchk("ctrl", ADDR_CTRL, 32'h0);
        rchk("rx_lines", ADDR_RX_LINES, 32'h3FF);
        rchk("tx_lines", ADDR_TX_LINES, 32'h3FF);
        rchk("din_map", ADDR_DIN_MAP, 32'h87654);
        wr(8'h40, 32'hFFFFFFFF);
        rchk("unmapped", 8'h40, 32'h0);
    endtask
    task automatic t_quad();
        wr(ADDR_RX_LINES, 32'h3);
        rdr(ADDR_RX_POS, p0);
        u_iopf_enc_model.quad(1'b1, 5);
        repeat (5) @(posedge core_clk);
        rchk("quad up", ADDR_RX_POS, (p0 + 5) % 16);
        u_iopf_enc_model.quad(1'b0, 7);
        repeat (5) @(posedge core_clk);
        rchk("quad wrap", ADDR_RX_POS, (p0 + 14) % 16);
    endtask
    task automatic t_step();
        wr(ADDR_CTRL, 32'h2);
        rdr(ADDR_RX_POS, p0);
        u_iopf_enc_model.step_dir(1'b1, 3);
        rchk("step up", ADDR_RX_POS, (p0 + 3) % 16);
        u_iopf_enc_model.step_dir(1'b0, 4);
        rchk("step down", ADDR_RX_POS, (p0 + 15) % 16);
    endtask
    task automatic t_index();
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_STATUS, 32'h4);
        rdr(ADDR_RX_POS, p0);
        u_iopf_enc_model.index_pulse();
        rdr(ADDR_STATUS, rd);
        chk("index seen", 32'h1, {31'h0, rd[ST_INDEX]});
        rchk("index latch", ADDR_RX_IDX, p0);
        wr(ADDR_CTRL, 32'h4);
        wr(ADDR_STATUS, 32'h4);
        u_iopf_enc_model.index_pulse();
        rdr(ADDR_STATUS, rd);
        chk("index off", 32'h0, {31'h0, rd[ST_INDEX]});
    endtask
    task automatic tx_burst(input logic [31:0] ctl, input logic [31:0] dl,
                            input int ea, input int en);
        wr(ADDR_CTRL, ctl);
        repeat (4) @(posedge core_clk);
        chk("tx oe_n", 32'h0, {29'h0, a_oe_n, b_oe_n, n_oe_n});
        a_edges = 0;
        b_edges = 0;
        n_rises = 0;
        wr(ADDR_TX_DELTA, dl);
        repeat (4 * dl + 10) @(posedge core_clk);
        chk("a edges", ea, a_edges);
        chk("b edges", ea, b_edges);
        chk("n rises", en, n_rises);
    endtask
    task automatic t_tx();
        wr(ADDR_TX_LINES, 32'h0);
        tx_burst(32'h1, 32'h8, 4, 2);
        tx_burst(32'h5, 32'h4, 2, 0);
        wr(ADDR_CTRL, 32'h0);
        repeat (2) @(posedge core_clk);
        chk("rx oe_n", 32'h7, {29'h0, a_oe_n, b_oe_n, n_oe_n});
    endtask
    task automatic t_filter();
        int n;
        din[5] <= 1'b1;
        repeat (2 * PC) @(posedge core_clk);
        din[5] <= 1'b0;
        repeat (8 * PC) @(posedge core_clk);
        chk("short pulse", 32'h0, {31'h0, controller_enable});
        din[5] <= 1'b1;
        cycles_to(0, 32'h1, 8 * PC, n);
        chk("filter late", 32'h1, {31'h0, n <= 5 * PC + 4});
        chk("filter early", 32'h1, {31'h0, n >= 3 * PC});
        din[6] <= 1'b1;
        repeat (6 * PC) @(posedge core_clk);
        chk("limit0", 32'h1, {30'h0, limit_hit});
        rchk("din level", ADDR_DIN, 32'h60);
        wr(ADDR_DIN_MAP, 32'h87604);
        repeat (2) @(posedge core_clk);
        chk("enable remap", 32'h0, {31'h0, controller_enable});
        wr(ADDR_DIN_MAP, {12'h0, MAP_RST});
    endtask
    task automatic t_dout();
        int n;
        wr(ADDR_DOUT, 32'h5);
        cycles_to(1, 32'h5, 4 * PC, n);
        chk("dout on", 32'h1, {31'h0, n <= PC + 2});
        wr(ADDR_DOUT, 32'h0);
        cycles_to(1, 32'h0, 4 * PC, n);
        chk("dout off", 32'h1, {31'h0, n <= PC + 2});
    endtask
    task automatic t_start();
        int n;
        wr(ADDR_CTRL, 32'h8);
        din[3:0] <= 4'hB;
        repeat (6 * PC) @(posedge core_clk);
        din[4] <= 1'b1;
        din[8] <= 1'b1;
        cycles_to(2, 32'h1, 10 * PC + IC, n);
        chk("start bound", 32'h1, {31'h0, n <= 5 * PC + IC + 4});
        chk("start filtered", 32'h1, {31'h0, n >= 3 * PC});
        chk("record", 32'hB, {28'h0, record_select});
        rdr(ADDR_STATUS, rd);
        chk("start cap", 32'h1, {31'h0, rd[ST_CAP_START]});
        chk("sample cap", 32'h1, {31'h0, rd[ST_CAP_SAMP]});
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_quad();
        t_step();
        t_index();
        t_tx();
        t_filter();
        t_dout();
        t_start();
        test_done();
    end
    initial begin
        repeat (100000) @(posedge core_clk);
        err_total++;
        test_done();
    end
endmodule
`default_nettype wire
